// file: dso_pkg.sv
// Package with option codes, register map and constants for drive status outputs.
package dso_pkg;

   // Option codes of the output functions handled here.
   localparam logic [5:0] DSO_OPT_COMM_LOSS = 6'h20;
   localparam logic [5:0] DSO_OPT_BOOL_ONE = 6'h21;
   localparam logic [5:0] DSO_OPT_BOOL_TWO = 6'h22;
   localparam logic [5:0] DSO_OPT_BOOL_THREE = 6'h23;
   localparam logic [5:0] DSO_OPT_CAP_WEAR = 6'h27;
   localparam logic [5:0] DSO_OPT_FAN_WEAR = 6'h28;
   localparam logic [5:0] DSO_OPT_RUN_REQ = 6'h29;
   localparam logic [5:0] DSO_OPT_HOT = 6'h2a;
   localparam logic [5:0] DSO_OPT_LOW_LOAD = 6'h2b;

   // Boolean operator encodings.
   typedef enum logic [1:0] {
      DSO_OP_AND = 2'h0,
      DSO_OP_OR = 2'h1,
      DSO_OP_XOR = 2'h2
   } dso_op_t;

   // Communication protocol selection values.
   localparam logic [1:0] DSO_PROTO_RTU = 2'h1;

   // Register offsets.
   localparam logic [3:0] DSO_REG_CTRL = 4'h0;
   localparam logic [3:0] DSO_REG_TRIP = 4'h1;
   localparam logic [3:0] DSO_REG_HOT_LVL = 4'h2;
   localparam logic [3:0] DSO_REG_LOAD_LVL = 4'h3;
   localparam logic [3:0] DSO_REG_BOOL1 = 4'h4;
   localparam logic [3:0] DSO_REG_BOOL2 = 4'h5;
   localparam logic [3:0] DSO_REG_BOOL3 = 4'h6;
   localparam logic [3:0] DSO_REG_ROUTE = 4'h7;
   localparam logic [3:0] DSO_REG_STATUS = 4'h8;
   localparam logic [3:0] DSO_REG_MONITOR = 4'h9;

   // Reset values.
   localparam logic [15:0] DSO_TRIP_RST = 16'h0000;
   localparam logic [15:0] DSO_LVL_RST = 16'h0000;
   localparam logic [17:0] DSO_ROUTE_RST = 18'h00000;
   localparam logic [13:0] DSO_BOOL_RST = 14'h0000;

   // Comm trip time unit, in microseconds, and its cycle count at 100 MHz.
   localparam int DSO_TRIP_UNIT_US = 1000;
   localparam int DSO_CLK_MHZ = 100;
   localparam int DSO_TRIP_UNIT_CYC = DSO_TRIP_UNIT_US * DSO_CLK_MHZ;

endpackage : dso_pkg

// file: dso_bool.sv
// One two-operand Boolean combiner over the status flags.
module dso_bool
   import dso_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Flag vector and configuration.
   input wire logic [63:0] flags,
   input wire logic [5:0] sel_a,
   input wire logic [5:0] sel_b,
   input wire logic [1:0] op,
   // Result.
   output logic result_q
);

   logic a_bit;
   logic b_bit;
   logic result_d;

   // Pick operands; combiner codes are masked by the caller.
   assign a_bit = flags[sel_a];
   assign b_bit = flags[sel_b];

   assign result_d = (op == DSO_OP_AND) ? (a_bit & b_bit) :
                     (op == DSO_OP_OR) ? (a_bit | b_bit) :
                     (op == DSO_OP_XOR) ? (a_bit ^ b_bit) : 1'b0;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         result_q <= 1'b0;
      end
      else
      begin
         result_q <= result_d;
      end
   end

endmodule : dso_bool

// file: dso_top.sv
// Status flag logic driving the programmable outputs of a motor drive.
// Operation
// - Comm loss flag only when the RTU protocol is selected.
// - After timeout the comm loss flag holds until next data received.
// - Timeout limit comes from the comm trip time setting.
// - Combiner takes two non-combiner flags with AND, OR or XOR.
// - Three independent combiners at option codes 33 to 35.
// - Per-terminal selector routes any flag to 11, 12 or relay.
// - Capacitor wear warning asserts when capacitor life expired.
// - Fan wear warning asserts when fan life expired.
// - Both wear warnings readable in a monitor register always.
// - Run request flag follows commands regardless of command source.
// - Forward and reverse together stop the motor.
// - Run request is low only when forward and reverse both given.
// - Heatsink warning while temperature exceeds the warning level.
// - Low load flag while current is below the threshold.
module dso_top
   import dso_pkg::*;
#(
   parameter int TRIP_UNIT_CYC = DSO_TRIP_UNIT_CYC,
   parameter int MEAS_W = 16
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Register port.
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Serial link events and life and measurement inputs.
   input wire logic rx_data_stb,
   input wire logic cap_life_expired,
   input wire logic fan_life_expired,
   input wire logic [MEAS_W-1:0] heatsink_temp,
   input wire logic [MEAS_W-1:0] output_current,
   // Run commands and other flags from the drive.
   input wire logic forward_run_command,
   input wire logic reverse_run_command,
   input wire logic [63:0] other_flags,
   // Drive outputs.
   output logic motor_stop,
   output logic out_term11,
   output logic out_term12,
   output logic out_relay
);

   import dso_pkg::*;

   // Last count of one trip time unit; the unit counter wraps there.
   // A wide counter keeps a slow unit of many cycles representable.
   localparam logic [31:0] UNIT_M1 = 32'(TRIP_UNIT_CYC - 1);

   // Configuration, counters and status flags.
   logic [1:0] proto_q;
   logic [15:0] trip_q;
   logic [MEAS_W-1:0] hot_lvl_q;
   logic [MEAS_W-1:0] load_lvl_q;
   logic [13:0] bool_cfg_q [3];
   logic [17:0] route_q;
   logic [31:0] unit_cnt_q;
   logic [15:0] trip_cnt_q;
   logic comm_loss_flag;
   logic capacitor_wear_warning;
   logic fan_wear_warning;
   logic run_request_flag;
   logic heatsink_hot_warning;
   logic low_load_flag;
   logic motor_stop_q;
   logic out_term11_q;
   logic out_term12_q;
   logic out_relay_q;
   // Combiner results and the flag vectors built around them.
   logic [2:0] bool_res;
   logic [63:0] flag_vec;
   logic [63:0] op_vec;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic rtu_sel;
   logic unit_tick;
   logic timeout_hit;

   // Register write decodes.
   // Unmapped indices match no decode, so writes there are dropped.
   wire wr_ctrl = reg_wr && (reg_addr == DSO_REG_CTRL);
   wire wr_trip = reg_wr && (reg_addr == DSO_REG_TRIP);
   wire wr_hot = reg_wr && (reg_addr == DSO_REG_HOT_LVL);
   wire wr_load = reg_wr && (reg_addr == DSO_REG_LOAD_LVL);
   wire wr_route = reg_wr && (reg_addr == DSO_REG_ROUTE);

   // Configuration registers.
   // Only the low bits of each written word are kept; the rest read zero.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         proto_q <= 2'h0;
         trip_q <= DSO_TRIP_RST;
         hot_lvl_q <= MEAS_W'(DSO_LVL_RST);
         load_lvl_q <= MEAS_W'(DSO_LVL_RST);
         route_q <= DSO_ROUTE_RST;
      end
      else
      begin
         if (wr_ctrl) proto_q <= reg_wdata[1:0];
         if (wr_trip) trip_q <= reg_wdata[15:0];
         if (wr_hot) hot_lvl_q <= reg_wdata[MEAS_W-1:0];
         if (wr_load) load_lvl_q <= reg_wdata[MEAS_W-1:0];
         if (wr_route) route_q <= reg_wdata[17:0];
      end
   end

   // Combiner configuration: sel_a[5:0], sel_b[11:6], op[13:12].
   // Each combiner keeps its own word, so the three run independently.
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_bool
         wire wr_b = reg_wr && (reg_addr == DSO_REG_BOOL1 + 4'(g));
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               bool_cfg_q[g] <= DSO_BOOL_RST;
            end
            else if (wr_b)
            begin
               bool_cfg_q[g] <= reg_wdata[13:0];
            end
         end
         dso_bool u_bool (
            .clk(clk),
            .rstn(rstn),
            .flags(op_vec),
            .sel_a(bool_cfg_q[g][5:0]),
            .sel_b(bool_cfg_q[g][11:6]),
            .op(bool_cfg_q[g][13:12]),
            .result_q(bool_res[g])
         );
      end
   endgenerate

   // Any other protocol keeps the timeout counters and loss flag cleared.
   // protocol gate
   assign rtu_sel = (proto_q == DSO_PROTO_RTU);
   assign unit_tick = (unit_cnt_q == UNIT_M1);
   assign timeout_hit = unit_tick && (trip_cnt_q + 16'h1 >= trip_q);

   // Reception timeout counters, restarted on every received datum.
   // Counting also stops while the loss flag stands, so a held flag never
   // wraps the counters or fires again before data returns.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         unit_cnt_q <= 32'h0;
         trip_cnt_q <= 16'h0;
      end
      else if (rx_data_stb || !rtu_sel || comm_loss_flag)
      begin
         unit_cnt_q <= 32'h0;
         trip_cnt_q <= 16'h0;
      end
      else if (unit_tick)
      begin
         unit_cnt_q <= 32'h0;
         trip_cnt_q <= trip_cnt_q + 16'h1;
      end
      else
      begin
         unit_cnt_q <= unit_cnt_q + 32'h1;
      end
   end

   // Status flags, all registered.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         comm_loss_flag <= 1'b0;
         capacitor_wear_warning <= 1'b0;
         fan_wear_warning <= 1'b0;
         run_request_flag <= 1'b0;
         heatsink_hot_warning <= 1'b0;
         low_load_flag <= 1'b0;
         motor_stop_q <= 1'b0;
      end
      else
      begin
         // Data wins over a timeout in the same cycle, so no datum is lost.
         // A trip time of zero turns the detection off altogether.
         // hold until data
         if (!rtu_sel || rx_data_stb)
            comm_loss_flag <= 1'b0;
         else if (timeout_hit && trip_q != 16'h0)
            comm_loss_flag <= 1'b1;
         // Lifetime figures are worked out elsewhere; only verdicts land here.
         // capacitor warning
         capacitor_wear_warning <= cap_life_expired;
         fan_wear_warning <= fan_life_expired;
         // Run request and motor stop are opposite views of one decode.
         // run request
         run_request_flag <= !(forward_run_command && reverse_run_command);
         motor_stop_q <= forward_run_command && reverse_run_command;
         // Equal levels leave both comparator flags clear.
         // heatsink compare
         heatsink_hot_warning <= (heatsink_temp > hot_lvl_q);
         low_load_flag <= (output_current < load_lvl_q);
      end
   end

   // Flag vector by option code; combiner codes feed only the routers.
   always_comb
   begin
      op_vec = other_flags;
      op_vec[DSO_OPT_COMM_LOSS] = comm_loss_flag;
      op_vec[DSO_OPT_CAP_WEAR] = capacitor_wear_warning;
      op_vec[DSO_OPT_FAN_WEAR] = fan_wear_warning;
      op_vec[DSO_OPT_RUN_REQ] = run_request_flag;
      op_vec[DSO_OPT_HOT] = heatsink_hot_warning;
      op_vec[DSO_OPT_LOW_LOAD] = low_load_flag;
      // Feeding a combiner result back would chain combiners through their
      // registers and make one result depend on another's history.
      // exclude combiner outputs
      op_vec[DSO_OPT_BOOL_ONE] = 1'b0;
      op_vec[DSO_OPT_BOOL_TWO] = 1'b0;
      op_vec[DSO_OPT_BOOL_THREE] = 1'b0;
      flag_vec = op_vec;
      flag_vec[DSO_OPT_BOOL_ONE] = bool_res[0];
      flag_vec[DSO_OPT_BOOL_TWO] = bool_res[1];
      flag_vec[DSO_OPT_BOOL_THREE] = bool_res[2];
   end

   // One register stage here puts a routed combiner two cycles behind
   // its inputs; relays do not notice, fast controllers might.
   // terminal routing
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         out_term11_q <= 1'b0;
         out_term12_q <= 1'b0;
         out_relay_q <= 1'b0;
      end
      else
      begin
         out_term11_q <= flag_vec[route_q[5:0]];
         out_term12_q <= flag_vec[route_q[11:6]];
         out_relay_q <= flag_vec[route_q[17:12]];
      end
   end

   // Read data selection.
   // The status word gathers every flag made here so software sees them in one read.
   always_comb
   begin
      case (reg_addr)
         DSO_REG_CTRL: rdata_d = {30'h0, proto_q};
         DSO_REG_TRIP: rdata_d = {16'h0, trip_q};
         DSO_REG_HOT_LVL: rdata_d = 32'(hot_lvl_q);
         DSO_REG_LOAD_LVL: rdata_d = 32'(load_lvl_q);
         DSO_REG_BOOL1: rdata_d = {18'h0, bool_cfg_q[0]};
         DSO_REG_BOOL2: rdata_d = {18'h0, bool_cfg_q[1]};
         DSO_REG_BOOL3: rdata_d = {18'h0, bool_cfg_q[2]};
         DSO_REG_ROUTE: rdata_d = {14'h0, route_q};
         DSO_REG_STATUS: rdata_d = {22'h0, motor_stop_q, bool_res,
            low_load_flag, heatsink_hot_warning, run_request_flag,
            fan_wear_warning, capacitor_wear_warning, comm_loss_flag};
         DSO_REG_MONITOR: rdata_d = {30'h0, fan_wear_warning,
            capacitor_wear_warning};
         default: rdata_d = 32'h0;
      endcase
   end

   // Read data register, valid only the cycle after a read strobe.
   // Returning zero outside the answer cycle keeps stale words off the bus.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rdata_q <= 32'h0;
      end
      else
      begin
         rdata_q <= reg_rd ? rdata_d : 32'h0;
      end
   end

   // Every output comes straight from a flip-flop.
   assign reg_rdata = rdata_q;
   assign motor_stop = motor_stop_q;
   assign out_term11 = out_term11_q;
   assign out_term12 = out_term12_q;
   assign out_relay = out_relay_q;

endmodule : dso_top

// file: dso_top_assertions.sv
// Checker of run request and register read timing at the top ports.
module dso_top_chk
   import dso_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Watched ports.
   input wire logic [3:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic forward_run_command,
   input wire logic reverse_run_command,
   input wire logic motor_stop
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Both commands given, and status or monitor reads.
   wire both = forward_run_command & reverse_run_command;
   wire st_rd = reg_rd & (reg_addr == DSO_REG_STATUS);
   wire mon_rd = reg_rd & (reg_addr == DSO_REG_MONITOR);
   property p_stop;
      both |=> motor_stop;
   endproperty
   a_stop: assert property (p_stop) else $error("stop missed");
   property p_run;
      !both |=> !motor_stop;
   endproperty
   a_run: assert property (p_run) else $error("stop stuck");
   property p_rise;
      $rose(motor_stop) |-> $past(both);
   endproperty
   a_rise: assert property (p_rise) else $error("stop cause");
   property p_st_stop;
      st_rd |=> reg_rdata[9] == $past(motor_stop);
   endproperty
   a_st_stop: assert property (p_st_stop) else $error("bit9");
   property p_st_req;
      st_rd |=> reg_rdata[3] == !$past(motor_stop);
   endproperty
   a_st_req: assert property (p_st_req) else $error("bit3");
   property p_st_hi;
      st_rd |=> reg_rdata[31:10] == 22'h0;
   endproperty
   a_st_hi: assert property (p_st_hi) else $error("status hi");
   property p_mon;
      mon_rd |=> reg_rdata[31:2] == 30'h0;
   endproperty
   a_mon: assert property (p_mon) else $error("monitor hi");
   property p_idle;
      !reg_rd |=> reg_rdata == 32'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("rdata idle");
endmodule : dso_top_chk

// file: dso_relay_model.sv
// Relay model that latches the three drive output terminals.
module dso_relay_model
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Terminals watched and coil states.
   input wire logic [2:0] term,
   output logic [2:0] coil_q
);
   timeunit 1ns;
   timeprecision 100ps;
   // Coils pull in one cycle after a terminal turns on.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         coil_q <= 3'h0;
      else
         coil_q <= term;
   end
endmodule : dso_relay_model

// file: dso_tb.sv
// Testbench for the drive status output block.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import dso_pkg::*;
   logic clk, rstn, reg_wr, reg_rd, rx, cap, fan, fwd, rev, stop;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d, v;
   logic [15:0] temp, cur;
   logic [63:0] oth;
   logic [2:0] term, coil;
   int miscompares = 0, n_compared = 0, cm = 0, hl, ll, bq[3];
   int msk[8] = '{32'h3, 32'hffff, 32'hffff, 32'hffff, 32'h3fff,
      32'h3fff, 32'h3fff, 32'h3ffff};
   int cd[6] = '{39, 40, 41, 42, 43, 33};
   dso_top #(.TRIP_UNIT_CYC(4)) u_dut (.clk(clk), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_data_stb(rx),
      .cap_life_expired(cap), .fan_life_expired(fan), .heatsink_temp(temp),
      .output_current(cur), .forward_run_command(fwd),
      .reverse_run_command(rev), .other_flags(oth), .motor_stop(stop),
      .out_term11(term[0]), .out_term12(term[1]), .out_relay(term[2]));
   dso_relay_model u_relay (.clk(clk), .rstn(rstn), .term(term),
      .coil_q(coil));
   // Reference value of one output function by option code.
   function automatic logic fl(int c, bit top = 1);
      logic a, b;
      int q;
      case (c)
         32: return cm[0];
         39: return cap;
         40: return fan;
         41: return !(fwd & rev);
         42: return temp > hl[15:0];
         43: return cur < ll[15:0];
         33, 34, 35:
         begin
            if (!top)
               return 1'b0;
            q = bq[c-33];
            a = fl(q[5:0], 0);
            b = fl(q[11:6], 0);
            case (q[13:12])
               0: return a & b;
               1: return a | b;
               2: return a ^ b;
               default: return 1'b0;
            endcase
         end
         default: return oth[c];
      endcase
   endfunction : fl
   // Reference status word.
   function automatic logic [31:0] exp_st();
      logic [31:0] s;
      s = {22'h0, fwd & rev, 9'h0};
      s[0] = cm[0];
      for (int c = 39; c <= 43; c++)
         s[c-38] = fl(c);
      for (int k = 0; k < 3; k++)
         s[6+k] = fl(33 + k);
      return s;
   endfunction : exp_st
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] x);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= x;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic st_chk();
      repeat (4) @(posedge clk);
      rd(DSO_REG_STATUS);
      chk("status", d, exp_st());
   endtask : st_chk
   task automatic complete_run();
      if (miscompares == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      {rstn, reg_wr, reg_rd, rx, cap, fan, fwd, rev} = 8'h0;
      {reg_addr, reg_wdata, temp, cur, oth} = '0;
      void'($urandom(32'he644));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      rd(DSO_REG_ROUTE);
      chk("route rst", d, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         v = $urandom & msk[i];
         wr(4'(i), v);
         rd(4'(i));
         chk("reg", d, v);
         if (i == 2)
            hl = v;
         if (i == 3)
            ll = v;
         if (i > 3 && i < 7)
            bq[i-4] = v;
      end
      wr(DSO_REG_CTRL, 32'h0);
      rd(DSO_REG_HOT_LVL);
      chk("hot level", d, hl);
      rd(DSO_REG_LOAD_LVL);
      chk("load level", d, ll);
      rd(4'hc);
      chk("unmapped", d, 32'h0);
      wr(DSO_REG_ROUTE, 32'd41 | (32'd39 << 6) | (32'd33 << 12));
      for (int i = 0; i < 64; i++)
      begin
         for (int k = 0; k < 3; k++)
         begin
            bq[k] = cd[$urandom % 6] | (cd[$urandom % 6] << 6);
            bq[k] = bq[k] | (((i + k) % 4) << 12);
            wr(DSO_REG_BOOL1 + 4'(k), bq[k]);
         end
         {fwd, rev, cap, fan} <= i[3:0];
         temp <= hl[15:0] + i[4];
         cur <= ll[15:0] - i[5];
         oth <= {$urandom, $urandom};
         st_chk();
         rd(DSO_REG_MONITOR);
         chk("monitor", d, {30'h0, fan, cap});
         chk("coils", coil, {fl(33), fl(39), fl(41)});
      end
      wr(DSO_REG_TRIP, 32'd3);
      wr(DSO_REG_CTRL, 32'h1);
      // Three units of four cycles: the flag is still clear twelve edges
      // after the protocol write and set two edges later.
      st_chk();
      st_chk();
      cm = 1;
      rd(DSO_REG_STATUS);
      chk("loss edge", d, exp_st());
      repeat (20) @(posedge clk);
      st_chk();
      @(posedge clk);
      rx <= 1'b1;
      @(posedge clk);
      rx <= 1'b0;
      cm = 0;
      st_chk();
      wr(DSO_REG_CTRL, 32'h2);
      repeat (20) @(posedge clk);
      st_chk();
      complete_run();
   end
endmodule : testbench
bind dso_top dso_top_chk u_chk (.clk(clk), .rstn(rstn),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .forward_run_command(forward_run_command),
   .reverse_run_command(reverse_run_command), .motor_stop(motor_stop));
